// File: rtl/cpg_pkg.sv
package cpg_pkg;

	// ==========================================================
	// Stage indices and counts
	localparam int         NUM_STAGES = 8;
	localparam logic [2:0] HS_A       = 3'h0;
	localparam logic [2:0] LS_A       = 3'h1;
	localparam logic [2:0] HS_B       = 3'h2;
	localparam logic [2:0] LS_B       = 3'h3;
	localparam logic [2:0] HS_C       = 3'h4;
	localparam logic [2:0] HS_D       = 3'h5;
	localparam logic [2:0] LS_C       = 3'h6;
	localparam logic [2:0] LS_D       = 3'h7;
	// Stages that are high-side drivers
	localparam logic [7:0] HS_MASK    = 8'h35;

	// ==========================================================
	// Register layout and reset values
	localparam logic [7:0] CFG_REG_RESET  = 8'h00;
	localparam logic [7:0] TDIS_REG_RESET = 8'h10;
	localparam int         TDIS_BIT       = 4;

	// ==========================================================
	// Grouping patterns of the configuration register
	localparam logic [7:0] CFG_QUAD       = 8'h08;
	localparam logic [7:0] CFG_PAIR_AB    = 8'h02;
	localparam logic [7:0] CFG_TWO_PAIRS  = 8'h04;
	localparam logic [7:0] CFG_TRIPLE     = 8'h8C;
	localparam logic [7:0] CFG_HS_SINGLE  = 8'h30;
	localparam logic [7:0] CFG_HS_PAIR_CD = 8'h31;
	localparam logic [7:0] CFG_HS_PAIR_AB = 8'h36;

	// ==========================================================
	// Fault codes, two bits per stage
	localparam logic [1:0] FLT_NONE = 2'h0;
	localparam logic [1:0] FLT_OPEN = 2'h1;
	localparam logic [1:0] FLT_SGND = 2'h2;
	localparam logic [1:0] FLT_OVC  = 2'h3;

	// ==========================================================
	// Overcurrent mask timing
	localparam int CLK_FREQ_KHZ       = 25000;
	localparam int OVC_MASK_SINGLE_NS = 4000;
	localparam int OVC_MASK_PAR_NS    = 8000;
	localparam int OVC_SINGLE_CYC     = (OVC_MASK_SINGLE_NS * CLK_FREQ_KHZ + 999999) / 1000000;
	localparam int OVC_PAR_CYC        = (OVC_MASK_PAR_NS * CLK_FREQ_KHZ + 999999) / 1000000;
	localparam int OVC_CNT_W          = 9;
	localparam logic [OVC_CNT_W-1:0] OVC_SINGLE_LIM = OVC_CNT_W'(OVC_SINGLE_CYC);
	localparam logic [OVC_CNT_W-1:0] OVC_PAR_LIM    = OVC_CNT_W'(OVC_PAR_CYC);

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		GRP_SINGLE,
		GRP_QUAD,
		GRP_PAIR_AB,
		GRP_TWO_PAIRS,
		GRP_TRIPLE,
		GRP_HS_SINGLE,
		GRP_HS_PAIR_CD,
		GRP_HS_PAIR_AB
	} cpg_mode_t;

	typedef struct packed {
		logic [2:0] src;
		logic       rep;
		logic       par;
	} cpg_route_t;

	typedef struct packed {
		logic ovc;
		logic openLoad;
		logic shortGnd;
	} cpg_raw_t;

endpackage

// File: rtl/cpg_ovc_filter.sv
`timescale 1ns/10ps
module cpg_ovc_filter
	import cpg_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic ovcRaw,
	input  wire logic longMask,
	output logic      ovcEvent
);

	logic [OVC_CNT_W-1:0] runCnt;
	logic [OVC_CNT_W-1:0] next_runCnt;
	logic [OVC_CNT_W-1:0] limit;
	logic                 next_ovcEvent;

	// ==========================================================
	// Mask counter: event once the raw level has held for the mask
	always_comb begin
		limit         = longMask ? OVC_PAR_LIM : OVC_SINGLE_LIM;
		next_runCnt   = runCnt;
		next_ovcEvent = 1'b0;
		if (!ovcRaw) begin
			next_runCnt = '0;
		end else if (runCnt < limit) begin
			next_runCnt   = runCnt + OVC_CNT_W'(1);
			next_ovcEvent = (runCnt == limit - OVC_CNT_W'(1));
		end
	end

	// Registers
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			runCnt   <= '0;
			ovcEvent <= 1'b0;
		end else begin
			runCnt   <= next_runCnt;
			ovcEvent <= next_ovcEvent;
		end
	end

	// ==========================================================
	// Checks: independent run length of the raw comparator
	logic [OVC_CNT_W-1:0] seenRaw;
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			seenRaw <= '0;
		end else begin
			seenRaw <= ovcRaw ? seenRaw + OVC_CNT_W'(1) : '0;
		end
	end

	a_mask_span: assert property (@(posedge ref_clk) disable iff (!resetn)
		ovcEvent |-> seenRaw == ($past(longMask) ? OVC_PAR_LIM : OVC_SINGLE_LIM))
		else $error("overcurrent event not at mask length");

	a_no_short_glitch: assert property (@(posedge ref_clk) disable iff (!resetn)
		!ovcRaw |=> !ovcEvent)
		else $error("overcurrent event after raw level dropped");

endmodule

// File: rtl/cpg_fault_latch.sv
`timescale 1ns/10ps
module cpg_fault_latch
	import cpg_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       ovcEvent,
	input  wire logic       onState,
	input  wire logic       offOpen,
	input  wire logic       offShortGnd,
	input  wire logic       clearRead,
	output logic      [1:0] code
);

	logic [1:0] next_code;
	logic [1:0] offCode;

	// ==========================================================
	// Latch: overcurrent overrides, first off fault holds, a read clears
	always_comb begin
		offCode = FLT_NONE;
		if (!onState) begin
			offCode = offShortGnd ? FLT_SGND : (offOpen ? FLT_OPEN : FLT_NONE);
		end
		if (ovcEvent) begin
			next_code = FLT_OVC;
		end else if (clearRead) begin
			next_code = offCode; // A new fault wins over the clear
		end else if (code == FLT_NONE) begin
			next_code = offCode;
		end else begin
			next_code = code;
		end
	end

	// Register
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			code <= FLT_NONE;
		end else begin
			code <= next_code;
		end
	end

	// ==========================================================
	// Checks
	a_ovc_overrides: assert property (@(posedge ref_clk) disable iff (!resetn)
		ovcEvent |=> code == FLT_OVC)
		else $error("overcurrent not latched");

	a_read_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
		(clearRead && !ovcEvent && (onState || (!offOpen && !offShortGnd))) |=> code == FLT_NONE)
		else $error("fault not cleared by diagnosis read");

	a_first_off_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
		(code == FLT_OPEN && !clearRead && !ovcEvent) |=> code == FLT_OPEN)
		else $error("latched off fault was overwritten");

endmodule

// File: rtl/cpg_parallel_config_decoder.sv
// Function
// - Grouping table applies only while table-disable bit 4 is zero; it resets to one.
// - Low-side stages not named by the active pattern run as independent single drivers; high sides stay off outside high-side patterns.
// - Paralleling joins channel A with B and C with D as low-side or high-side pairs.
// - Pattern bit 3 alone: all four low sides one stage, diagnosed on A.
// - Bit 1 alone: A+B pair enabled by B, diagnosed A; bit 2 alone gives A+B and C+D pairs.
// - Bits 7,3,2: low sides B, C, D one stage, enabled and diagnosed on B.
// - High-side single pattern: every driver switched by its own command.
// - High-side C+D and low-side A+B pairs; enable LS B, HS C; diagnose LS A, HS C.
// - Pattern 0x36: HS A+B and LS C+D pairs; enable HS B, LS C.
// - Paralleled stages double the overcurrent mask from 4 us to 8 us.
// - Each stage keeps its own overcurrent and off-state thresholds regardless.
// - Each stage latches a two-bit fault code, cleared on a diagnosis read unless a fault is present in that cycle.
`timescale 1ns/10ps
module cpg_parallel_config_decoder
	import cpg_pkg::*;
(
	input  wire logic                        ref_clk,
	input  wire logic                        resetn,
	input  wire logic                        cfgWrEn,
	input  wire logic      [7:0]             cfgWrData,
	input  wire logic                        tableDisWrEn,
	input  wire logic      [7:0]             tableDisWrData,
	input  wire logic                        diagRead,
	input  wire logic      [NUM_STAGES-1:0]  stageCmd,
	input  wire cpg_raw_t  [NUM_STAGES-1:0]  stageRaw,
	output logic           [7:0]             cfgReadData,
	output logic           [7:0]             tableDisReadData,
	output cpg_mode_t                        activeMode,
	output logic           [NUM_STAGES-1:0]  stageDrive,
	output logic           [NUM_STAGES-1:0]  stageParallel,
	output logic [NUM_STAGES-1:0][1:0]       diagCode
);

	// ==========================================================
	// Declarations
	logic      [7:0]                 next_cfgReg;
	logic      [7:0]                 next_tdisReg;
	cpg_mode_t                       next_mode;
	logic      [NUM_STAGES-1:0]      next_drive;
	logic      [NUM_STAGES-1:0]      next_parallel;
	logic [NUM_STAGES-1:0][1:0]      next_diag;
	cpg_route_t                      route [NUM_STAGES];
	logic                            hsAllowed;
	logic      [NUM_STAGES-1:0]      groupTrip;
	logic      [NUM_STAGES-1:0]      ovcEvent;
	logic [NUM_STAGES-1:0][1:0]      latched;

	// ==========================================================
	// Register writes
	always_comb begin
		next_cfgReg  = cfgWrEn ? cfgWrData : cfgReadData;
		next_tdisReg = tableDisWrEn ? tableDisWrData : tableDisReadData;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cfgReadData      <= CFG_REG_RESET;
			tableDisReadData <= TDIS_REG_RESET;
		end else begin
			cfgReadData      <= next_cfgReg;
			tableDisReadData <= next_tdisReg;
		end
	end

	// ==========================================================
	// Pattern decode from the stored registers
	always_comb begin
		next_mode = GRP_SINGLE;
		if (!tableDisReadData[TDIS_BIT]) begin
			case (cfgReadData)
				CFG_QUAD:       next_mode = GRP_QUAD;
				CFG_PAIR_AB:    next_mode = GRP_PAIR_AB;
				CFG_TWO_PAIRS:  next_mode = GRP_TWO_PAIRS;
				CFG_TRIPLE:     next_mode = GRP_TRIPLE;
				CFG_HS_SINGLE:  next_mode = GRP_HS_SINGLE;
				CFG_HS_PAIR_CD: next_mode = GRP_HS_PAIR_CD;
				CFG_HS_PAIR_AB: next_mode = GRP_HS_PAIR_AB;
				default:        next_mode = GRP_SINGLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			activeMode <= GRP_SINGLE;
		end else begin
			activeMode <= next_mode;
		end
	end

	// ==========================================================
	// Routing of enable source, reporting stage and parallel flag
	always_comb begin
		for (int i = 0; i < NUM_STAGES; i++) begin
			route[i].src = 3'(i);
			route[i].rep = 1'b1;
			route[i].par = 1'b0;
		end
		hsAllowed = 1'b0;
		case (activeMode)
			GRP_QUAD: begin
				route[LS_A] = '{src: LS_A, rep: 1'b1, par: 1'b1};
				route[LS_B] = '{src: LS_A, rep: 1'b0, par: 1'b1};
				route[LS_C] = '{src: LS_A, rep: 1'b0, par: 1'b1};
				route[LS_D] = '{src: LS_A, rep: 1'b0, par: 1'b1};
			end
			GRP_PAIR_AB: begin
				route[LS_A] = '{src: LS_B, rep: 1'b1, par: 1'b1};
				route[LS_B] = '{src: LS_B, rep: 1'b0, par: 1'b1};
			end
			GRP_TWO_PAIRS: begin
				route[LS_A] = '{src: LS_B, rep: 1'b1, par: 1'b1};
				route[LS_B] = '{src: LS_B, rep: 1'b0, par: 1'b1};
				route[LS_C] = '{src: LS_C, rep: 1'b1, par: 1'b1};
				route[LS_D] = '{src: LS_C, rep: 1'b0, par: 1'b1};
			end
			GRP_TRIPLE: begin
				route[LS_B] = '{src: LS_B, rep: 1'b1, par: 1'b1};
				route[LS_C] = '{src: LS_B, rep: 1'b0, par: 1'b1};
				route[LS_D] = '{src: LS_B, rep: 1'b0, par: 1'b1};
			end
			GRP_HS_SINGLE: begin
				hsAllowed = 1'b1;
			end
			GRP_HS_PAIR_CD: begin
				hsAllowed   = 1'b1;
				route[HS_C] = '{src: HS_C, rep: 1'b1, par: 1'b1};
				route[HS_D] = '{src: HS_C, rep: 1'b0, par: 1'b1};
				route[LS_A] = '{src: LS_B, rep: 1'b1, par: 1'b1};
				route[LS_B] = '{src: LS_B, rep: 1'b0, par: 1'b1};
			end
			GRP_HS_PAIR_AB: begin
				hsAllowed   = 1'b1;
				route[HS_A] = '{src: HS_B, rep: 1'b0, par: 1'b1};
				route[HS_B] = '{src: HS_B, rep: 1'b1, par: 1'b1};
				route[LS_C] = '{src: LS_C, rep: 1'b1, par: 1'b1};
				route[LS_D] = '{src: LS_C, rep: 1'b0, par: 1'b1};
			end
			default: begin
				hsAllowed = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Drive, group shutdown and diagnosis reporting
	always_comb begin
		for (int i = 0; i < NUM_STAGES; i++) begin
			groupTrip[i] = 1'b0;
			next_diag[i] = FLT_NONE;
			for (int j = 0; j < NUM_STAGES; j++) begin
				if (route[j].src == route[i].src) begin
					groupTrip[i] = groupTrip[i] | (latched[j] == FLT_OVC);
					// Worst code of the group goes to the reporting stage
					if (route[i].rep && latched[j] > next_diag[i]) begin
						next_diag[i] = latched[j];
					end
				end
			end
			next_drive[i]    = stageCmd[route[i].src] & ~groupTrip[i] & (hsAllowed | ~HS_MASK[i]);
			next_parallel[i] = route[i].par;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			stageDrive    <= '0;
			stageParallel <= '0;
			diagCode      <= '0;
		end else begin
			stageDrive    <= next_drive;
			stageParallel <= next_parallel;
			diagCode      <= next_diag;
		end
	end

	// ==========================================================
	// Per-stage overcurrent filter and fault latch
	for (genvar g = 0; g < NUM_STAGES; g++) begin : gStage
		cpg_ovc_filter uFilter (
			.ref_clk  (ref_clk),
			.resetn   (resetn),
			.ovcRaw   (stageRaw[g].ovc),
			.longMask (stageParallel[g]),
			.ovcEvent (ovcEvent[g])
		);
		cpg_fault_latch uLatch (
			.ref_clk     (ref_clk),
			.resetn      (resetn),
			.ovcEvent    (ovcEvent[g]),
			.onState     (stageDrive[g]),
			.offOpen     (stageRaw[g].openLoad),
			.offShortGnd (stageRaw[g].shortGnd),
			.clearRead   (diagRead),
			.code        (latched[g])
		);
	end

	// ==========================================================
	// Checks
	sequence s_quad_live;
		activeMode == GRP_QUAD && !groupTrip[LS_A];
	endsequence

	sequence s_pair_live;
		activeMode == GRP_PAIR_AB && !groupTrip[LS_B];
	endsequence

	a_table_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
		tableDisReadData[TDIS_BIT] |=> activeMode == GRP_SINGLE)
		else $error("grouping active while table disabled");

	a_quad_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_quad_live |=> stageDrive[LS_D] == $past(stageCmd[LS_A]) && stageDrive[LS_B] == stageDrive[LS_D])
		else $error("quad stage not driven by stage A command");

	a_pair_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_pair_live |=> stageDrive[LS_A] == $past(stageCmd[LS_B]))
		else $error("pair not driven by stage B command");

	a_single_rest: assert property (@(posedge ref_clk) disable iff (!resetn)
		(activeMode == GRP_PAIR_AB && latched[LS_C] != FLT_OVC) |=> stageDrive[LS_C] == $past(stageCmd[LS_C]))
		else $error("unnamed stage not single");

	a_triple_diag: assert property (@(posedge ref_clk) disable iff (!resetn)
		activeMode == GRP_TRIPLE |=> diagCode[LS_C] == FLT_NONE && diagCode[LS_D] == FLT_NONE)
		else $error("triple group reported on a member stage");

	a_hs_pair_ab: assert property (@(posedge ref_clk) disable iff (!resetn)
		(activeMode == GRP_HS_PAIR_AB && !groupTrip[HS_A]) |=> stageDrive[HS_A] == $past(stageCmd[HS_B]))
		else $error("high-side pair A not driven by B command");

	a_hs_blocked: assert property (@(posedge ref_clk) disable iff (!resetn)
		(activeMode == GRP_SINGLE) |=> (stageDrive & HS_MASK) == '0)
		else $error("high side driven outside a high-side pattern");

	a_long_mask: assert property (@(posedge ref_clk) disable iff (!resetn)
		activeMode == GRP_TWO_PAIRS |=> stageParallel[LS_D] && !stageParallel[HS_A])
		else $error("mask length not following grouping");

	// Pair tripped by an overcurrent on its enabling stage
	sequence s_pair_tripped;
		activeMode == GRP_PAIR_AB && latched[LS_B] == FLT_OVC;
	endsequence

	a_pair_report: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_pair_tripped |=> diagCode[LS_A] == FLT_OVC && diagCode[LS_B] == FLT_NONE)
		else $error("pair overcurrent not reported on stage A");

	a_group_shut: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_pair_tripped |=> !stageDrive[LS_A] && !stageDrive[LS_B])
		else $error("paralleled pair still driven after overcurrent");

	a_two_pairs_en: assert property (@(posedge ref_clk) disable iff (!resetn)
		(activeMode == GRP_TWO_PAIRS && !groupTrip[LS_C]) |=>
			stageDrive[LS_D] == $past(stageCmd[LS_C]) && stageDrive[LS_C] == stageDrive[LS_D])
		else $error("second pair not driven by stage C command");

	a_triple_en: assert property (@(posedge ref_clk) disable iff (!resetn)
		(activeMode == GRP_TRIPLE && !groupTrip[LS_B]) |=>
			stageDrive[LS_D] == $past(stageCmd[LS_B]) && stageDrive[LS_C] == stageDrive[LS_B])
		else $error("triple group not driven by stage B command");

	a_hs_single_en: assert property (@(posedge ref_clk) disable iff (!resetn)
		(activeMode == GRP_HS_SINGLE && !groupTrip[HS_D]) |=> stageDrive[HS_D] == $past(stageCmd[HS_D]))
		else $error("single high side not following its own command");

	a_hs_cd_en: assert property (@(posedge ref_clk) disable iff (!resetn)
		(activeMode == GRP_HS_PAIR_CD && !groupTrip[HS_C]) |=>
			stageDrive[HS_D] == $past(stageCmd[HS_C]) && stageDrive[HS_C] == stageDrive[HS_D])
		else $error("high-side pair C not driven by C command");

	a_hs_cd_low: assert property (@(posedge ref_clk) disable iff (!resetn)
		(activeMode == GRP_HS_PAIR_CD && !groupTrip[LS_A]) |=> stageDrive[LS_A] == $past(stageCmd[LS_B]))
		else $error("low-side pair not driven by stage B command");

	a_hs_cd_report: assert property (@(posedge ref_clk) disable iff (!resetn)
		activeMode == GRP_HS_PAIR_CD |=> diagCode[LS_B] == FLT_NONE && diagCode[HS_D] == FLT_NONE)
		else $error("high-side C pattern reported on a member stage");

	a_hs_ab_low: assert property (@(posedge ref_clk) disable iff (!resetn)
		(activeMode == GRP_HS_PAIR_AB && !groupTrip[LS_C]) |=> stageDrive[LS_D] == $past(stageCmd[LS_C]))
		else $error("low-side pair not driven by stage C command");

	a_hs_ab_report: assert property (@(posedge ref_clk) disable iff (!resetn)
		activeMode == GRP_HS_PAIR_AB |=> diagCode[LS_D] == FLT_NONE && diagCode[HS_A] == FLT_NONE)
		else $error("high-side A pattern reported on a member stage");

	a_mode_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
		(!tableDisReadData[TDIS_BIT] && cfgReadData == CFG_QUAD) |=> activeMode == GRP_QUAD)
		else $error("enabled table not decoded");

	a_single_flat: assert property (@(posedge ref_clk) disable iff (!resetn)
		activeMode == GRP_SINGLE |=> stageParallel == '0)
		else $error("stage marked parallel in single mode");

	a_single_report: assert property (@(posedge ref_clk) disable iff (!resetn)
		activeMode == GRP_SINGLE |=> diagCode[LS_C] == $past(latched[LS_C]))
		else $error("single stage not reporting its own code");

	a_quad_report: assert property (@(posedge ref_clk) disable iff (!resetn)
		activeMode == GRP_QUAD |=> diagCode[LS_B] == FLT_NONE && diagCode[LS_D] == FLT_NONE)
		else $error("quad group reported on a member stage");

endmodule

// File: test/cpg_parallel_config_decoder_tb_top.sv
`timescale 1ns/10ps
module cpg_parallel_config_decoder_tb_top;
	import cpg_pkg::*;

	// ==========================================================
	// Signals
	logic                            ref_clk;
	logic                            resetn;
	logic                            cfgWrEn;
	logic      [7:0]                 cfgWrData;
	logic                            tableDisWrEn;
	logic      [7:0]                 tableDisWrData;
	logic                            diagRead;
	logic      [NUM_STAGES-1:0]      stageCmd;
	cpg_raw_t  [NUM_STAGES-1:0]      stageRaw;
	logic      [7:0]                 cfgReadData;
	logic      [7:0]                 tableDisReadData;
	cpg_mode_t                       activeMode;
	logic      [NUM_STAGES-1:0]      stageDrive;
	logic      [NUM_STAGES-1:0]      stageParallel;
	logic      [NUM_STAGES-1:0][1:0] diagCode;
	int                              failCount;
	int                              checked;
	int                              cycles;
	int                              n;

	// ==========================================================
	// Pattern table: value, decoded mode, parallel mask, command, drive
	localparam logic [7:0] PAT [0:7] = '{CFG_QUAD, CFG_PAIR_AB, CFG_TWO_PAIRS, CFG_TRIPLE,
		CFG_HS_SINGLE, CFG_HS_PAIR_CD, CFG_HS_PAIR_AB, 8'h55};
	localparam cpg_mode_t  MODE [0:7] = '{GRP_QUAD, GRP_PAIR_AB, GRP_TWO_PAIRS, GRP_TRIPLE,
		GRP_HS_SINGLE, GRP_HS_PAIR_CD, GRP_HS_PAIR_AB, GRP_SINGLE};
	localparam logic [7:0] PARM [0:7] = '{8'hCA, 8'h0A, 8'hCA, 8'hC8, 8'h00, 8'h3A, 8'hC5, 8'h00};
	localparam logic [7:0] CMD  [0:7] = '{8'h03, 8'h48, 8'h40, 8'h0A, 8'h21, 8'h18, 8'h44, 8'h1A};
	localparam logic [7:0] DRV  [0:7] = '{8'hCA, 8'h4A, 8'hC0, 8'hCA, 8'h21, 8'h3A, 8'hC5, 8'h0A};

	// ==========================================================
	// Clock and cycle ceiling
	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failCount = failCount + 1;
			$display("wrong value: run length exceeded");
			finishTest();
		end
	end

	cpg_parallel_config_decoder dut (
		.ref_clk          (ref_clk),
		.resetn           (resetn),
		.cfgWrEn          (cfgWrEn),
		.cfgWrData        (cfgWrData),
		.tableDisWrEn     (tableDisWrEn),
		.tableDisWrData   (tableDisWrData),
		.diagRead         (diagRead),
		.stageCmd         (stageCmd),
		.stageRaw         (stageRaw),
		.cfgReadData      (cfgReadData),
		.tableDisReadData (tableDisReadData),
		.activeMode       (activeMode),
		.stageDrive       (stageDrive),
		.stageParallel    (stageParallel),
		.diagCode         (diagCode)
	);

	// ==========================================================
	// Tasks
	task automatic step(input int k);
		repeat (k) @(negedge ref_clk);
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			failCount = failCount + 1;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Register writes are one-cycle strobes launched at the falling edge
	task automatic wrCfg(input logic [7:0] d);
		cfgWrEn = 1'b1;
		cfgWrData = d;
		step(1);
		cfgWrEn = 1'b0;
		step(4);
	endtask

	task automatic wrTdis(input logic [7:0] d);
		tableDisWrEn = 1'b1;
		tableDisWrData = d;
		step(1);
		tableDisWrEn = 1'b0;
		step(4);
	endtask

	task automatic pulseRead();
		diagRead = 1'b1;
		step(1);
		diagRead = 1'b0;
		step(3);
	endtask

	// Count edges until the reporting stage shows an overcurrent code
	task automatic waitOvc(input int idx);
		n = 0;
		while (diagCode[idx] !== FLT_OVC && n < 400) begin
			step(1);
			n = n + 1;
		end
	endtask

	task automatic finishTest();
		$display("comparisons %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		failCount = 0;
		checked = 0;
		cycles = 0;
		resetn = 1'b0;
		cfgWrEn = 1'b0;
		cfgWrData = 8'h00;
		tableDisWrEn = 1'b0;
		tableDisWrData = 8'h00;
		diagRead = 1'b0;
		stageCmd = 8'h00;
		stageRaw = '0;
		step(4);
		resetn = 1'b1;
		step(1);
		check("cfg reset", cfgReadData, CFG_REG_RESET);
		check("tdis reset", tableDisReadData, TDIS_REG_RESET);
		check("mode reset", {5'h00, activeMode}, {5'h00, GRP_SINGLE});
		check("diag reset low", diagCode[3:0], 8'h00);
		check("diag reset high", diagCode[7:4], 8'h00);
		$display("test reset done");

		// Table stays inactive while the disable bit is set
		stageCmd = 8'h02;
		wrCfg(CFG_QUAD);
		check("cfg readback", cfgReadData, CFG_QUAD);
		check("mode disabled", {5'h00, activeMode}, {5'h00, GRP_SINGLE});
		check("par disabled", stageParallel, 8'h00);
		check("drive disabled", stageDrive, 8'h02);
		wrTdis(8'h00);
		check("tdis readback", tableDisReadData, 8'h00);
		$display("test table disable done");

		// Every grouping pattern, including an unlisted one
		// paths never shorted
		for (int i = 0; i < 8; i++) begin
			stageCmd = CMD[i];
			wrCfg(PAT[i]);
			check("mode", {5'h00, activeMode}, {5'h00, MODE[i]});
			check("parallel", stageParallel, PARM[i]);
			check("drive", stageDrive, DRV[i]);
		end
		$display("test grouping table done");

		// Off-state faults in single mode: first one kept, ignored while driven
		stageCmd = 8'h40;
		step(2);
		stageRaw[LS_C].openLoad = 1'b1;
		stageRaw[LS_D].openLoad = 1'b1;
		step(3);
		check("open driven", {6'h00, diagCode[LS_C]}, {6'h00, FLT_NONE});
		check("open off", {6'h00, diagCode[LS_D]}, {6'h00, FLT_OPEN});
		stageRaw[LS_D].shortGnd = 1'b1;
		step(3);
		check("first kept", {6'h00, diagCode[LS_D]}, {6'h00, FLT_OPEN});
		// A fault present in the read cycle survives the clear
		stageRaw[LS_D].openLoad = 1'b0;
		step(1);
		pulseRead();
		check("short after read", {6'h00, diagCode[LS_D]}, {6'h00, FLT_SGND});
		stageRaw = '0;
		step(1);
		pulseRead();
		check("open cleared", {6'h00, diagCode[LS_D]}, {6'h00, FLT_NONE});
		$display("test off-state diagnosis done");

		// Single-stage overcurrent mask
		stageRaw[LS_C].ovc = 1'b1;
		waitOvc(LS_C);
		check("single mask", 8'(n >= 100 && n <= 103), 8'h01);
		check("single shut", {7'h00, stageDrive[LS_C]}, 8'h00);
		stageRaw = '0;
		step(1);
		pulseRead();
		check("ovc cleared", {6'h00, diagCode[LS_C]}, {6'h00, FLT_NONE});
		$display("test single overcurrent done");

		// Paralleled pair: doubled mask, report on the diagnosing stage
		stageCmd = 8'h08;
		wrCfg(CFG_PAIR_AB);
		check("pair drive", stageDrive, 8'h0A);
		check("pair parallel", stageParallel, 8'h0A);
		stageRaw[LS_B].ovc = 1'b1;
		waitOvc(LS_A);
		check("pair mask", 8'(n >= 200 && n <= 203), 8'h01);
		check("member code", {6'h00, diagCode[LS_B]}, {6'h00, FLT_NONE});
		check("pair shut", stageDrive, 8'h00);
		stageRaw = '0;
		step(1);
		pulseRead();
		check("pair cleared", {6'h00, diagCode[LS_A]}, {6'h00, FLT_NONE});
		step(2);
		check("pair resumed", stageDrive, 8'h0A);
		$display("test parallel overcurrent done");

		finishTest();
	end

endmodule
